/* inc/nibble_core_pkg.sv */
// shared constants, types and decode function for the nibble decoder core
package nibble_core_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 4;
  localparam int ADDR_W = 7;
  localparam int WR_W = 4;
  localparam int INSTR_W = 16;
  localparam int TADDR_W = 8;

  // ---------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------
  localparam int OPC5_LSB = 11; // five-bit opcode, [15:11]
  localparam int OPC8_LSB = 8;  // eight-bit opcode, [15:8]
  localparam int OPC9_LSB = 7;  // nine-bit opcode, [15:7]
  localparam int WRM_LSB = 7;   // working register beside a memory address
  localparam int IMM_LSB = 4;   // immediate nibble
  localparam int WRI_LSB = 0;   // working register beside an immediate
  localparam int MEM_LSB = 0;   // direct memory address

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [4:0] OPC_MOVE_WR_TO_MEM = 5'h07;
  localparam logic [4:0] OPC_MOVE_MEM_TO_WR = 5'h0D;
  localparam logic [7:0] OPC_OR_IMM = 8'h1E;
  localparam logic [7:0] OPC_OR_STORE_IMM = 8'h1F;
  localparam logic [8:0] OPC_LOAD_PTR_LOW = 9'h130;
  localparam logic [8:0] OPC_LOAD_PTR_HIGH = 9'h131;
  localparam logic [8:0] OPC_TABLE_READ = 9'h132;
  localparam logic [8:0] OPC_OR_MEM = 9'h034;
  localparam logic [8:0] OPC_OR_STORE_MEM = 9'h03B;
  localparam logic [8:0] OPC_ROTATE_LEFT = 9'h099;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] PTR_RST = 4'h0;
  localparam logic [3:0] MEM_RST = 4'h0;
  localparam logic [2:0] WR_PAGE = 3'h0; // working registers sit at 00..0F
  localparam int TABLE_CYCLES = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_MOVE_WR_TO_MEM = 4'h1,
    OP_MOVE_MEM_TO_WR = 4'h2,
    OP_LOAD_PTR_LOW = 4'h3,
    OP_LOAD_PTR_HIGH = 4'h4,
    OP_TABLE_READ = 4'h5,
    OP_OR_MEM = 4'h6,
    OP_OR_IMM = 4'h7,
    OP_OR_STORE_MEM = 4'h8,
    OP_OR_STORE_IMM = 4'h9,
    OP_ROTATE_LEFT = 4'hA
  } op_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_TABLE = 1'b1
  } state_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } flags_t;

  typedef struct packed {
    op_t op;
    logic [6:0] memAddr;
    logic [3:0] wrIdx;
    logic [3:0] imm;
  } decoded_t;

  // split an instruction word into operation and operands
  function automatic decoded_t decodeInstr(input logic [15:0] w);
    decoded_t d;
    d.op = OP_NONE;
    d.memAddr = w[MEM_LSB +: ADDR_W];
    d.wrIdx = w[WRM_LSB +: WR_W];
    d.imm = w[IMM_LSB +: DATA_W];
    if (w[OPC5_LSB +: 5] == OPC_MOVE_WR_TO_MEM) begin
      d.op = OP_MOVE_WR_TO_MEM;
    end else if (w[OPC5_LSB +: 5] == OPC_MOVE_MEM_TO_WR) begin
      d.op = OP_MOVE_MEM_TO_WR;
    end else if (w[OPC8_LSB +: 8] == OPC_OR_IMM) begin
      d.op = OP_OR_IMM;
      d.wrIdx = w[WRI_LSB +: WR_W];
    end else if (w[OPC8_LSB +: 8] == OPC_OR_STORE_IMM) begin
      d.op = OP_OR_STORE_IMM;
      d.wrIdx = w[WRI_LSB +: WR_W];
    end else begin
      case (w[OPC9_LSB +: 9])
        OPC_LOAD_PTR_LOW: d.op = OP_LOAD_PTR_LOW;
        OPC_LOAD_PTR_HIGH: d.op = OP_LOAD_PTR_HIGH;
        OPC_TABLE_READ: d.op = OP_TABLE_READ;
        OPC_OR_MEM: d.op = OP_OR_MEM;
        OPC_OR_STORE_MEM: d.op = OP_OR_STORE_MEM;
        OPC_ROTATE_LEFT: d.op = OP_ROTATE_LEFT;
        default: d.op = OP_NONE;
      endcase
    end
    return d;
  endfunction

endpackage

/* hw/data_nibble_mem.sv */
// flip-flop data memory, one combinational read port, one write port
`timescale 1ns/1ps
module data_nibble_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] memReg [DEPTH];

  // storage, cleared on reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        memReg[i] <= DATA_W'(nibble_core_pkg::MEM_RST);
      end
    end else if (wrEn) begin
      memReg[wrAddr] <= wrData;
    end
  end

  // read is asynchronous within the cycle
  assign rdData = memReg[rdAddr];
endmodule

/* hw/nibble_decoder_core.sv */
// instruction decoder and datapath for move, table, or and rotate ops
`timescale 1ns/1ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module nibble_decoder_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [3:0] tableData,
  output logic busy,
  output logic [3:0] acc,
  output nibble_core_pkg::flags_t flags,
  output logic [3:0] tablePtrLow,
  output logic [3:0] tablePtrHigh,
  output logic [7:0] tableAddr
);

  // ---------------------------------------------------------------
  // state and datapath signals
  // ---------------------------------------------------------------
  nibble_core_pkg::state_t stateReg;
  nibble_core_pkg::decoded_t dec;
  nibble_core_pkg::op_t op;
  logic accept;
  logic [3:0] accReg;
  logic carryReg;
  logic zeroReg;
  logic [3:0] ptrLowReg;
  logic [3:0] ptrHighReg;
  logic [7:0] tableAddrReg;
  logic [6:0] pendAddrReg;
  logic [6:0] rdAddr;
  logic [6:0] wrRegAddr;
  logic [3:0] rdData;
  logic wrEn;
  logic [6:0] wrAddr;
  logic [3:0] wrData;
  logic accLoad;
  logic [3:0] accNext;
  logic carryLoad;
  logic carryNext;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // a new instruction is taken only while not in a table read
  assign accept = instrValid && (stateReg == nibble_core_pkg::ST_RUN);
  assign dec = nibble_core_pkg::decodeInstr(instrWord);
  assign op = accept ? dec.op : nibble_core_pkg::OP_NONE;
  assign wrRegAddr = {nibble_core_pkg::WR_PAGE, dec.wrIdx};

  // read the working register for register-sourced ops, else memory
  always_comb begin
    case (op)
      nibble_core_pkg::OP_MOVE_WR_TO_MEM,
      nibble_core_pkg::OP_OR_IMM,
      nibble_core_pkg::OP_OR_STORE_IMM: rdAddr = wrRegAddr;
      default: rdAddr = dec.memAddr;
    endcase
  end

  data_nibble_mem #(
    .ADDR_W(nibble_core_pkg::ADDR_W),
    .DATA_W(nibble_core_pkg::DATA_W)
  ) u_mem (
    .mclk(mclk),
    .rst(rst),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData)
  );

  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  // result, write port and flag updates per operation
  always_comb begin
    wrEn = 1'b0;
    wrAddr = dec.memAddr;
    wrData = rdData;
    accLoad = 1'b0;
    accNext = accReg;
    carryLoad = 1'b0;
    carryNext = carryReg;
    if (stateReg == nibble_core_pkg::ST_TABLE) begin
      wrEn = 1'b1;
      wrAddr = pendAddrReg;
      wrData = tableData;
    end else begin
      case (op)
        nibble_core_pkg::OP_MOVE_WR_TO_MEM: begin
          accLoad = 1'b1;
          accNext = rdData;
          wrEn = 1'b1;
        end
        nibble_core_pkg::OP_MOVE_MEM_TO_WR: begin
          accLoad = 1'b1;
          accNext = rdData;
          wrEn = 1'b1;
          wrAddr = wrRegAddr;
        end
        nibble_core_pkg::OP_OR_MEM: begin
          accLoad = 1'b1;
          accNext = rdData | accReg;
        end
        nibble_core_pkg::OP_OR_IMM: begin
          accLoad = 1'b1;
          accNext = rdData | dec.imm;
        end
        nibble_core_pkg::OP_OR_STORE_MEM: begin
          accLoad = 1'b1;
          accNext = rdData | accReg;
          wrEn = 1'b1;
          wrData = accNext;
        end
        nibble_core_pkg::OP_OR_STORE_IMM: begin
          accLoad = 1'b1;
          accNext = rdData | dec.imm;
          wrEn = 1'b1;
          wrAddr = wrRegAddr;
          wrData = accNext;
        end
        nibble_core_pkg::OP_ROTATE_LEFT: begin
          accLoad = 1'b1;
          accNext = {rdData[2:0], carryReg};
          carryLoad = 1'b1;
          carryNext = rdData[3];
          wrEn = 1'b1;
          wrData = accNext;
        end
        default: begin
          accLoad = 1'b0;
        end
      endcase
    end
  end

  // accumulator and zero flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      accReg <= nibble_core_pkg::ACC_RST;
      zeroReg <= 1'b0;
    end else if (accLoad) begin
      accReg <= accNext;
      zeroReg <= (accNext == 4'h0);
    end
  end

  // carry flag, touched only by the rotate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      carryReg <= 1'b0;
    end else if (carryLoad) begin
      carryReg <= carryNext;
    end
  end

  // table pointers, flags left alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptrLowReg <= nibble_core_pkg::PTR_RST;
      ptrHighReg <= nibble_core_pkg::PTR_RST;
    end else begin
      if (op == nibble_core_pkg::OP_LOAD_PTR_LOW) begin
        ptrLowReg <= rdData;
      end
      if (op == nibble_core_pkg::OP_LOAD_PTR_HIGH) begin
        ptrHighReg <= rdData;
      end
    end
  end

  // table read sequencer: address out, then capture the nibble
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg <= nibble_core_pkg::ST_RUN;
      tableAddrReg <= 8'h00;
      pendAddrReg <= 7'h00;
    end else begin
      case (stateReg)
        nibble_core_pkg::ST_RUN: begin
          if (op == nibble_core_pkg::OP_TABLE_READ) begin
            stateReg <= nibble_core_pkg::ST_TABLE;
            tableAddrReg <= {ptrHighReg, ptrLowReg};
            pendAddrReg <= dec.memAddr;
          end
        end
        nibble_core_pkg::ST_TABLE: begin
          stateReg <= nibble_core_pkg::ST_RUN;
        end
        default: begin
          stateReg <= nibble_core_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busy = (stateReg == nibble_core_pkg::ST_TABLE);
  assign acc = accReg;
  assign flags = '{carry: carryReg, zero: zeroReg};
  assign tablePtrLow = ptrLowReg;
  assign tablePtrHigh = ptrHighReg;
  assign tableAddr = tableAddrReg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_move_wr_mem: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_MOVE_WR_TO_MEM
      |-> wrEn && wrAddr == dec.memAddr ##1 accReg == $past(rdData))
    else $error("wr to mem move wrong");
  a_move_mem_wr: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_MOVE_MEM_TO_WR
      |-> wrEn && wrAddr[6:4] == 3'h0 && wrData == rdData
      ##1 accReg == $past(wrData))
    else $error("mem to wr move wrong");
  a_ptr_low: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_LOAD_PTR_LOW
      |=> ptrLowReg == $past(rdData) && $stable(flags) && $stable(accReg))
    else $error("low pointer load wrong");
  a_ptr_high: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_LOAD_PTR_HIGH
      |=> ptrHighReg == $past(rdData) && $stable(flags))
    else $error("high pointer load wrong");
  a_table_read: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_TABLE_READ
      |=> busy && tableAddr == {$past(ptrHighReg), $past(ptrLowReg)}
      && wrEn && wrAddr == $past(dec.memAddr) && wrData == tableData
      && $stable(flags) && $stable(accReg) ##1 !busy)
    else $error("table read sequence wrong");
  a_or_mem: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_OR_MEM
      |-> !wrEn ##1 accReg == ($past(rdData) | $past(accReg)))
    else $error("or into accumulator wrong");
  a_or_imm: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_OR_IMM
      |-> !wrEn ##1 accReg == ($past(rdData) | $past(dec.imm)))
    else $error("or immediate wrong");
  a_or_store: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_OR_STORE_MEM
      |-> wrEn && wrAddr == dec.memAddr && wrData == (rdData | accReg)
      ##1 accReg == $past(wrData))
    else $error("or and store wrong");
  a_or_store_imm: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_OR_STORE_IMM
      |-> wrEn && wrAddr == wrRegAddr && wrData == (rdData | dec.imm)
      ##1 accReg == $past(wrData))
    else $error("or store immediate wrong");
  a_rotate_carry: assert property (@(posedge mclk) disable iff (rst)
    op == nibble_core_pkg::OP_ROTATE_LEFT
      |=> carryReg == $past(rdData[3])
      && accReg == {$past(rdData[2:0]), $past(carryReg)})
    else $error("rotate through carry wrong");
  a_zero_flag: assert property (@(posedge mclk) disable iff (rst)
    accLoad |=> zeroReg == (accReg == 4'h0))
    else $error("zero flag mismatch");
  a_flags_hold: assert property (@(posedge mclk) disable iff (rst)
    !accLoad && !carryLoad |=> $stable(flags) && $stable(accReg))
    else $error("flags or accumulator moved without an op");
endmodule

/* bench/test_nibble_cpu_move_or_rotate_ops.sv */
// self-checking bench for the nibble decoder core with a reference model
`timescale 1ns/1ps
module test_nibble_cpu_move_or_rotate_ops;
  // ---------------------------------------------------------------
  // design ports and model state
  // ---------------------------------------------------------------
  logic mclk;
  logic rst;
  logic instrValid;
  logic [15:0] instrWord;
  logic [3:0] tableData;
  logic busy;
  logic [3:0] acc;
  nibble_core_pkg::flags_t flags;
  logic [3:0] tablePtrLow;
  logic [3:0] tablePtrHigh;
  logic [7:0] tableAddr;
  logic [3:0] memModel [0:127];
  logic [3:0] accExp;
  logic carryExp;
  logic zeroExp;
  logic [3:0] ptrLowExp;
  logic [3:0] ptrHighExp;
  logic [7:0] tableAddrExp;
  integer seed;
  int fails;
  int samples_checked;
  int n;

  nibble_decoder_core nibble_decoder_core_i (
    .mclk(mclk),
    .rst(rst),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .tableData(tableData),
    .busy(busy),
    .acc(acc),
    .flags(flags),
    .tablePtrLow(tablePtrLow),
    .tablePtrHigh(tablePtrHigh),
    .tableAddr(tableAddr)
  );

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    summarize();
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // build an instruction word from an operation index
  function automatic logic [15:0] encode(input int k, input logic [6:0] r,
                                         input logic [3:0] w,
                                         input logic [3:0] i);
    case (k)
      0: return {nibble_core_pkg::OPC_MOVE_WR_TO_MEM, w, r};
      1: return {nibble_core_pkg::OPC_MOVE_MEM_TO_WR, w, r};
      2: return {nibble_core_pkg::OPC_LOAD_PTR_LOW, r};
      3: return {nibble_core_pkg::OPC_LOAD_PTR_HIGH, r};
      4: return {nibble_core_pkg::OPC_TABLE_READ, r};
      5: return {nibble_core_pkg::OPC_OR_MEM, r};
      6: return {nibble_core_pkg::OPC_OR_IMM, i, w};
      7: return {nibble_core_pkg::OPC_OR_STORE_MEM, r};
      8: return {nibble_core_pkg::OPC_OR_STORE_IMM, i, w};
      9: return {nibble_core_pkg::OPC_ROTATE_LEFT, r};
      default: return 16'h0000;
    endcase
  endfunction

  // reference update for one accepted instruction
  task automatic apply(input int k, input logic [6:0] r, input logic [3:0] w,
                       input logic [3:0] i);
    logic [3:0] v;
    v = accExp;
    case (k)
      0: v = memModel[w];
      1: v = memModel[r];
      2: ptrLowExp = memModel[r];
      3: ptrHighExp = memModel[r];
      4: tableAddrExp = {ptrHighExp, ptrLowExp};
      5: v = memModel[r] | accExp;
      6: v = memModel[w] | i;
      7: v = memModel[r] | accExp;
      8: v = memModel[w] | i;
      9: begin
        v = {memModel[r][2:0], carryExp};
        carryExp = memModel[r][3];
      end
      default: v = accExp;
    endcase
    if (k == 0 || k == 7 || k == 9) memModel[r] = v;
    if (k == 1 || k == 8) memModel[w] = v;
    if (k == 0 || k == 1 || (k >= 5 && k <= 9)) begin
      accExp = v;
      zeroExp = (v == 4'h0);
    end
  endtask

  task automatic resetModel();
    for (int a = 0; a < 128; a++) memModel[a] = 4'h0;
    accExp = 4'h0;
    carryExp = 1'b0;
    zeroExp = 1'b0;
    ptrLowExp = 4'h0;
    ptrHighExp = 4'h0;
    tableAddrExp = 8'h00;
  endtask

  task automatic checkState();
    check(8'(acc), 8'(accExp));
    check(8'(flags), {6'h00, carryExp, zeroExp});
    check({tablePtrHigh, tablePtrLow}, {ptrHighExp, ptrLowExp});
    check({7'h00, busy}, 8'h00);
    check(tableAddr, tableAddrExp);
  endtask

  // present one instruction, check the state left by all earlier ones
  task automatic step(input int k, input logic [6:0] r, input logic [3:0] w,
                      input logic [3:0] i);
    logic [3:0] td;
    @(posedge mclk);
    instrValid <= 1'b1;
    instrWord <= encode(k, r, w, i);
    #1;
    checkState();
    apply(k, r, w, i);
    if (k == 4) begin
      td = 4'($random(seed));
      @(posedge mclk);
      instrWord <= encode(8, 7'h00, 4'h0, 4'hF); // must be ignored
      tableData <= td;
      #1;
      check({7'h00, busy}, 8'h01);
      check(tableAddr, tableAddrExp);
      memModel[r] = td;
    end
  endtask

  task automatic randomStep();
    int k;
    logic [6:0] r;
    k = {$random(seed)} % 11;
    r = 7'($random(seed));
    if (r[6:5] != 2'b11) r = r & 7'h1F;
    step(k, r, 4'($random(seed)), 4'($random(seed)));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 85;
    fails = 0;
    samples_checked = 0;
    rst = 1'b1;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    tableData = 4'h0;
    resetModel();
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // corners: zero result, rotate carry chain, back-to-back table reads
    step(6, 7'h00, 4'h3, 4'h0);
    step(8, 7'h00, 4'h0, 4'hF);
    step(9, 7'h00, 4'h0, 4'h0);
    step(9, 7'h00, 4'h0, 4'h0);
    step(2, 7'h00, 4'h0, 4'h0);
    step(8, 7'h00, 4'h1, 4'hA);
    step(3, 7'h01, 4'h0, 4'h0);
    step(4, 7'h7F, 4'h0, 4'h0);
    step(4, 7'h7F, 4'h0, 4'h0);
    step(1, 7'h7F, 4'h2, 4'h0);
    step(7, 7'h7F, 4'h0, 4'h0);
    step(10, 7'h00, 4'h0, 4'h0);
    // random traffic in two blocks, with a reset after each
    for (n = 0; n < 2; n++) begin
      repeat (800) randomStep();
      @(posedge mclk);
      rst <= 1'b1;
      instrValid <= 1'b0;
      #1;
      resetModel();
      checkState();
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
    end
    step(1, 7'h7F, 4'h5, 4'h0);
    step(10, 7'h00, 4'h0, 4'h0);
    summarize();
  end
endmodule
